// [csfs_pkg.sv]
// What this block does
// - Three separate 8-bit switching-frequency registers exist, for channels A, B and C, at consecutive addresses.
// - Bits 7:6 choose the sync multiple: 00 is one times, 01 is two times the sync input, 10 and 11 are reserved.
// - Bits 5:0 are a code that picks the channel frequency from a fixed table, code 0 being 48.8 kHz.
// - Codes 1 to 7 give 55.8, 60.1, 65.1, 71.0, 78.1, 86.8 and 97.7 kHz.
// - Codes 8 to 15 give 104.2, 111.6, 120.2, 130.2, 135.9, 142.0, 148.8 and 156.3 kHz.
// - Codes 16 to 24 give 164.5, 173.6, 183.8, 195.3, 201.6, 208.3, 215.5, 223.2 and 231.5 kHz.
// - Codes above 24 continue the table upward to 312.5 kHz at code 31 and 625.0 kHz at code 63.
// - With sync enabled a channel times its switching clock from the sync reference or its multiple.
package csfs_pkg;
   localparam int CLK_KHZ = 250000;
   localparam int ADDR_W = 18;
   localparam int CNT_W = 16;
   // printed offsets are not word aligned: they are indices, byte address is four times
   localparam int CHAN_A_IDX = 'hfe0a;
   localparam int CHAN_B_IDX = 'hfe0b;
   localparam int CHAN_C_IDX = 'hfe0c;
   localparam int SYNC_EN_IDX = 'hfe0e;
   localparam int SYNC_PER_IDX = 'hfe40;
   localparam logic [ADDR_W-1:0] CHAN_A_ADDR = ADDR_W'(4 * CHAN_A_IDX);
   localparam logic [ADDR_W-1:0] SYNC_EN_ADDR = ADDR_W'(4 * SYNC_EN_IDX);
   localparam logic [ADDR_W-1:0] SYNC_PER_ADDR = ADDR_W'(4 * SYNC_PER_IDX);
   localparam logic [7:0] CHAN_RESET = 8'h00;
   localparam logic [2:0] SYNC_EN_RESET = 3'h0;
   localparam logic [CNT_W-1:0] SYNC_PER_RESET = 16'hffff;
   localparam logic [1:0] MULT_X1 = 2'h0;
   localparam logic [1:0] MULT_X2 = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // frequency of each code in units of 0.1 kHz
   localparam int FREQ_DK [64] = '{
      488, 558, 601, 651, 710, 781, 868, 977,
      1042, 1116, 1202, 1302, 1359, 1420, 1488, 1563,
      1645, 1736, 1838, 1953, 2016, 2083, 2155, 2232,
      2315, 2404, 2500, 2604, 2717, 2841, 2976, 3125,
      3205, 3289, 3378, 3472, 3571, 3676, 3788, 3906,
      3968, 4032, 4098, 4167, 4237, 4310, 4386, 4464,
      4545, 4630, 4717, 4808, 4902, 5000, 5102, 5208,
      5319, 5435, 5556, 5682, 5814, 5952, 6098, 6250};

   typedef struct packed {
      logic [1:0] mult;
      logic [5:0] code;
   } csfs_cfg_type;

   typedef struct packed {
      logic [2:0] sw_clk;
      logic [2:0] period_start;
   } csfs_chan_out_type;

   typedef enum logic [2:0] {
      SEL_CHAN_A,
      SEL_CHAN_B,
      SEL_CHAN_C,
      SEL_SYNC_EN,
      SEL_SYNC_PER,
      SEL_NONE
   } csfs_sel_type;
endpackage

// [csfs_sync_src.sv]
`timescale 1ns/10ps
module csfs_sync_src (
   input wire logic run, // edges while high
   input wire logic [15:0] half_ns, // half period
   output logic sync_input_pin // toward device
);
   // idle low outside bursts; 1 ns offset keeps edges clear of the device clock
   always begin
      sync_input_pin = 1'b0;
      wait (run);
      #1;
      while (run) begin
         sync_input_pin = 1'b1;
         #(half_ns);
         sync_input_pin = 1'b0;
         #(half_ns);
      end
   end
endmodule

// [csfs_top.sv]
`timescale 1ns/10ps
module csfs_top #(
   parameter int CNT_W = 16
) (
   input wire logic aclk, // 250 MHz
   input wire logic aresetn, // synchronous, active low
   input wire logic [csfs_pkg::ADDR_W-1:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write byte strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [csfs_pkg::ADDR_W-1:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic sync_input_pin, // external sync, asynchronous
   output csfs_pkg::csfs_chan_out_type chan_out // per-channel switching clock and boundary
);
   import csfs_pkg::*;

   function automatic csfs_sel_type decode(input logic [ADDR_W-1:0] a);
      if (a == CHAN_A_ADDR) begin
         return SEL_CHAN_A;
      end else if (a == CHAN_A_ADDR + ADDR_W'(4)) begin
         return SEL_CHAN_B;
      end else if (a == CHAN_A_ADDR + ADDR_W'(8)) begin
         return SEL_CHAN_C;
      end else if (a == SYNC_EN_ADDR) begin
         return SEL_SYNC_EN;
      end else if (a == SYNC_PER_ADDR) begin
         return SEL_SYNC_PER;
      end else begin
         return SEL_NONE;
      end
   endfunction

   csfs_cfg_type cfg_ff [3];
   logic [2:0] sync_en_ff;
   logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic do_write;
   csfs_sel_type wsel, rsel;
   logic sync_s1_ff, sync_s2_ff, sync_s3_ff;
   logic sync_edge;
   logic [CNT_W-1:0] sync_cnt_ff, sync_per_ff;

   assign awready = !aw_hold_ff && !bvalid_ff;
   assign wready = !w_hold_ff && !bvalid_ff;
   assign arready = !rvalid_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wsel = decode(awaddr_ff);
   assign rsel = decode(araddr);

   // address and data are taken in either order and held until both are present
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         awaddr_ff <= '0;
      end else if (awvalid && awready) begin
         aw_hold_ff <= 1'b1;
         awaddr_ff <= awaddr;
      end else if (do_write) begin
         aw_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_ff <= 1'b0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end else if (wvalid && wready) begin
         w_hold_ff <= 1'b1;
         wdata_ff <= wdata;
         wstrb_ff <= wstrb;
      end else if (do_write) begin
         w_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (wsel == SEL_NONE || wsel == SEL_SYNC_PER) ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // only byte lane 0 carries register data; a write with wstrb[0] low changes nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff[0] <= CHAN_RESET;
         cfg_ff[1] <= CHAN_RESET;
         cfg_ff[2] <= CHAN_RESET;
         sync_en_ff <= SYNC_EN_RESET;
      end else if (do_write && wstrb_ff[0]) begin
         if (wsel == SEL_CHAN_A) begin
            cfg_ff[0] <= wdata_ff[7:0];
         end else if (wsel == SEL_CHAN_B) begin
            cfg_ff[1] <= wdata_ff[7:0];
         end else if (wsel == SEL_CHAN_C) begin
            cfg_ff[2] <= wdata_ff[7:0];
         end else if (wsel == SEL_SYNC_EN) begin
            sync_en_ff <= wdata_ff[2:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= RESP_OKAY;
         case (rsel)
            SEL_CHAN_A: rdata_ff <= {24'h000000, cfg_ff[0]};
            SEL_CHAN_B: rdata_ff <= {24'h000000, cfg_ff[1]};
            SEL_CHAN_C: rdata_ff <= {24'h000000, cfg_ff[2]};
            SEL_SYNC_EN: rdata_ff <= {29'h00000000, sync_en_ff};
            SEL_SYNC_PER: rdata_ff <= 32'(sync_per_ff);
            default: begin
               rdata_ff <= '0;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // two flops before anything looks at the pin; edge detect reads the second and third only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_s1_ff <= 1'b0;
         sync_s2_ff <= 1'b0;
         sync_s3_ff <= 1'b0;
      end else begin
         sync_s1_ff <= sync_input_pin;
         sync_s2_ff <= sync_s1_ff;
         sync_s3_ff <= sync_s2_ff;
      end
   end
   assign sync_edge = sync_s2_ff && !sync_s3_ff;

   // measured sync period in clocks; starts at full scale so no channel runs away before lock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_cnt_ff <= '0;
         sync_per_ff <= SYNC_PER_RESET;
      end else if (sync_edge) begin
         sync_cnt_ff <= '0;
         // a saturated count must not wrap to zero, or every channel with sync enabled would wrap each clock
         sync_per_ff <= (sync_cnt_ff == '1) ? sync_cnt_ff : sync_cnt_ff + CNT_W'(1);
      end else if (sync_cnt_ff != '1) begin
         sync_cnt_ff <= sync_cnt_ff + CNT_W'(1);
      end
   end

   for (genvar i = 0; i < 3; i++) begin : g_chan
      logic [CNT_W-1:0] period_tbl [64];
      logic [CNT_W-1:0] cnt_ff, per_ff, target, nxt_cnt;
      csfs_cfg_type act_cfg_ff;
      logic act_sync_ff, wrap, sw_clk_ff, start_ff;

      for (genvar k = 0; k < 64; k++) begin : g_tbl
         // period in clocks, rounded down, for every code of the table
         assign period_tbl[k] = CNT_W'(CLK_KHZ * 10 / FREQ_DK[k]);
      end

      // reserved multiple codes fall back to one times the sync input
      always_comb begin
         if (act_sync_ff) begin
            target = (act_cfg_ff.mult == MULT_X2) ? (sync_per_ff >> 1) : sync_per_ff;
            wrap = sync_edge || (cnt_ff + CNT_W'(1) >= target);
         end else begin
            target = per_ff;
            wrap = (cnt_ff + CNT_W'(1) >= target);
         end
         nxt_cnt = wrap ? '0 : cnt_ff + CNT_W'(1);
      end

      // settings are sampled only at the boundary, so no period is cut short by a write
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cnt_ff <= '0;
            act_cfg_ff <= CHAN_RESET;
            act_sync_ff <= 1'b0;
            per_ff <= period_tbl[0];
         end else begin
            cnt_ff <= nxt_cnt;
            if (wrap) begin
               act_cfg_ff <= cfg_ff[i];
               act_sync_ff <= sync_en_ff[i];
               per_ff <= period_tbl[cfg_ff[i].code];
            end
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            sw_clk_ff <= 1'b0;
            start_ff <= 1'b0;
         end else begin
            sw_clk_ff <= nxt_cnt < (target >> 1) || wrap;
            start_ff <= wrap;
         end
      end

      assign chan_out.sw_clk[i] = sw_clk_ff;
      assign chan_out.period_start[i] = start_ff;
   end
endmodule

// [csfs_top_properties.sv]
`timescale 1ns/10ps
module csfs_top_checker (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset
   input wire logic awvalid, // aw
   input wire logic awready, // aw
   input wire logic wvalid, // w
   input wire logic wready, // w
   input wire logic [1:0] bresp, // b
   input wire logic bvalid, // b
   input wire logic bready, // b
   input wire logic arvalid, // ar
   input wire logic arready, // ar
   input wire logic [31:0] rdata, // r
   input wire logic rvalid, // r
   input wire logic rready, // r
   input wire csfs_pkg::csfs_chan_out_type chan_out // channels
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   w_block_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken during response");
   ar_block_a: assert property (rvalid |-> !arready)
      else $error("read taken during response");
   r_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   b_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write not answered");
   pulse_one_a: assert property (chan_out.period_start != 3'h0 |=>
      (chan_out.period_start & $past(chan_out.period_start)) == 3'h0)
      else $error("boundary pulse too long");
   reset_out_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && chan_out == '0)
      else $error("outputs not idle after reset");
   clk_start_a: assert property ((chan_out.period_start & ~chan_out.sw_clk) == 3'h0)
      else $error("clock low at period start");
endmodule
bind csfs_top csfs_top_checker i_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
   .rready(rready), .chan_out(chan_out));

// [csfs_top_test.sv]
`timescale 1ns/10ps
module csfs_top_test;
   import csfs_pkg::*;
   localparam int DK[6] = '{977, 1042, 2315, 3125, 6250, 488};
   localparam int CD[6] = '{7, 8, 24, 31, 63, 0};
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic awready, wready, bvalid, arready, rvalid, sync_input_pin;
   logic [1:0] bresp, rresp;
   csfs_chan_out_type chan_out;
   int n_mismatch = 0, num_checks = 0;
   always #2 aclk = ~aclk;
   csfs_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sync_input_pin(sync_input_pin), .chan_out(chan_out));
   csfs_sync_src i_sync (.run(run), .half_ns(16'd2000), .sync_input_pin(sync_input_pin));
   task automatic report_and_stop;
      $display("mismatches %0d checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 20000) begin
         chk(32'h0, 32'h1, "wait ran out");
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic [1:0] got;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 20000; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      got = bresp;
      bready <= 1'b0;
      @(posedge aclk);
      tmo(n);
      chk(32'(got), 32'(er), "bresp");
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic [31:0] gd;
      logic [1:0] gr;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 20000; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      gd = rdata;
      gr = rresp;
      rready <= 1'b0;
      @(posedge aclk);
      tmo(n);
      chk(gd, ed, "rdata");
      chk(32'(gr), 32'(er), "rresp");
   endtask
   // ex of 0 skips the period check; the boundary is still checked against lim
   task automatic per(input int ch, input int ex, input int lim);
      int n, c;
      @(posedge aclk);
      for (n = 0; n < 20000 && chan_out.period_start[ch] !== 1'b1; n++) @(posedge aclk);
      tmo(n);
      chk(32'(n <= lim), 32'h1, "boundary late");
      chk(32'(chan_out.sw_clk[ch]), 32'h1, "clock low at boundary");
      @(posedge aclk);
      for (c = 1; c < 20000 && chan_out.period_start[ch] !== 1'b1; c++) @(posedge aclk);
      tmo(c);
      if (ex > 0) chk(32'(c), 32'(ex), "period");
   endtask
   initial begin
      int i;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 3; i++) rd(CHAN_A_ADDR + ADDR_W'(4 * i), 32'h0, RESP_OKAY);
      rd(18'h00010, 32'h0, RESP_SLVERR);
      wr(CHAN_A_ADDR + 18'h4, 8'hc5, RESP_OKAY);
      rd(CHAN_A_ADDR + 18'h4, 32'hc5, RESP_OKAY);
      wr(18'h00010, 8'h11, RESP_SLVERR);
      wr(CHAN_A_ADDR + 18'h8, 8'h1f, RESP_OKAY);
      per(2, 800, 5130);
      for (i = 0; i < 6; i++) begin
         wr(CHAN_A_ADDR, 8'(CD[i]), RESP_OKAY);
         per(0, 2500000 / DK[i], 2500000 / DK[(i + 5) % 6] + 8);
      end
      run <= 1'b1;
      wr(SYNC_EN_ADDR, 8'h01, RESP_OKAY);
      rd(SYNC_EN_ADDR, 32'h1, RESP_OKAY);
      per(0, 0, 6000);
      per(0, 0, 1100);
      rd(SYNC_PER_ADDR, 32'd1000, RESP_OKAY);
      per(0, 1000, 1100);
      wr(CHAN_A_ADDR, 8'h40, RESP_OKAY);
      per(0, 500, 1100);
      wr(CHAN_A_ADDR, 8'h80, RESP_OKAY);
      per(0, 1000, 600);
      wr(SYNC_PER_ADDR, 8'h00, RESP_SLVERR);
      run <= 1'b0;
      report_and_stop();
   end
endmodule
